// ===== rtl/smsf_cfg.svh
// constants of the secondary measurement status block
`ifndef SMSF_CFG_SVH
`define SMSF_CFG_SVH

`define SMSF_AW 16
`define SMSF_DW 16

`define SMSF_OFF_STATUS 16'h1C3E
`define SMSF_OFF_SYNC_FIRST 16'h1C40
`define SMSF_OFF_SYNC_LAST 16'h1C51
`define SMSF_OFF_APP_FIRST 16'h1C53
`define SMSF_OFF_APP_LAST 16'h1C56
`define SMSF_OFF_PER_FIRST 16'h1C73
`define SMSF_OFF_PER_LAST 16'h1C7F
`define SMSF_OFF_PER_CTRL 16'h1C30
`define SMSF_OFF_IRQ_STAT 16'h1C20
`define SMSF_OFF_IRQ_CLR 16'h1C21
`define SMSF_OFF_IRQ_EN 16'h1C22

`define SMSF_BIT_SUPPLY 12
`define SMSF_BIT_FAST 10
`define SMSF_BIT_SYNC 9
`define SMSF_BIT_PER 8
`define SMSF_BIT_APP_LO 0
`define SMSF_BIT_APP_HI 3

`define SMSF_PMODE_OFF 2'h0
`define SMSF_PMODE_AUTO 2'h1
`define SMSF_PMODE_ONCE 2'h2
`define SMSF_PMODE_RST 2'h0

`define SMSF_IRQ_FAST 0
`define SMSF_IRQ_SYNC 1
`define SMSF_IRQ_PER 2
`define SMSF_IRQ_SUPPLY 3
`define SMSF_IRQ_W 4

`define SMSF_APP_SAMPLES 16
`define SMSF_APP_INVALID 16'h8000
`define SMSF_APP_N 4

`endif

// ===== rtl/smsf_pkg.sv
// types of the secondary measurement status block
`include "smsf_cfg.svh"

package smsf_pkg;

	typedef logic [1:0] smsf_pmode_t;

	typedef struct packed {
		logic [`SMSF_AW-1:0] addr;
		logic [`SMSF_DW-1:0] wdata;
		logic wr;
		logic rd;
	} smsf_bus_t;

	typedef struct packed {
		logic fast_done;
		logic sync_done;
		logic per_done;
	} smsf_evt_t;

endpackage

// ===== rtl/smsf_status.sv
// secondary measurement status flags with application result registers
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "smsf_cfg.svh"

// Contract
// - bit 12 reads 1 while a supply error is detected, else 0; resets 0.
// - reserved bits 11 and 7:4 always read zero.
// - bit 10 sets on fast data; clears on sync result read or sync cycle end.
// - bit 9 sets on sync data; clears on sync result read or fast cycle end.
// - bit 8 sets whenever a new periodic result set is generated.
// - in automatic mode any read of periodic result range clears bit 8.
// - in single-request mode writing single-request clears bit 8; reads do not.
// - bits 3:0 read 1 once an input holds at least 16 samples.
// - an application result register returns to 8000h right after it is read; a capture accepted in the read cycle loads the new value instead.
module smsf_status
	import smsf_pkg::*;
#(
	parameter int APP_N = `SMSF_APP_N,
	parameter int APP_SAMPLES = `SMSF_APP_SAMPLES
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [`SMSF_AW-1:0] ADDR_IN,
	input wire logic [`SMSF_DW-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [`SMSF_DW-1:0] RDATA_OUT,
	input wire logic SUPPLY_FAULT_IN,
	input wire logic FAST_DONE_IN,
	input wire logic SYNC_DONE_IN,
	input wire logic PER_DONE_IN,
	input wire logic [APP_N-1:0] APP_SAMPLE_IN,
	input wire logic [APP_N-1:0] APP_CAPTURE_IN,
	input wire logic [`SMSF_DW-1:0] APP_VALUE_IN,
	output logic [1:0] PER_MODE_OUT,
	output logic PER_REQUEST_OUT,
	output logic IRQ_OUT
);

	localparam int CW = $clog2(APP_SAMPLES + 1);
	localparam logic [CW-1:0] SAMPLES_FULL = CW'(APP_SAMPLES);

	////////////////////////////////////////////////////////////////////////////
	// request bundling

	smsf_bus_t bus;
	smsf_evt_t evt;

	assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};
	assign evt = '{fast_done: FAST_DONE_IN, sync_done: SYNC_DONE_IN, per_done: PER_DONE_IN};

	logic rd_sync_range;
	logic rd_per_range;
	logic wr_ctrl;
	logic wr_once;
	logic wr_irq_clr;
	logic wr_irq_en;

	assign rd_sync_range = bus.rd && bus.addr >= `SMSF_OFF_SYNC_FIRST && bus.addr <= `SMSF_OFF_SYNC_LAST;
	assign rd_per_range = bus.rd && bus.addr >= `SMSF_OFF_PER_FIRST && bus.addr <= `SMSF_OFF_PER_LAST;
	assign wr_ctrl = bus.wr && bus.addr == `SMSF_OFF_PER_CTRL;
	assign wr_once = wr_ctrl && bus.wdata[1:0] == `SMSF_PMODE_ONCE;
	assign wr_irq_clr = bus.wr && bus.addr == `SMSF_OFF_IRQ_CLR;
	assign wr_irq_en = bus.wr && bus.addr == `SMSF_OFF_IRQ_EN;

	////////////////////////////////////////////////////////////////////////////
	// supply fault input, asynchronous to our clock

	logic sup_s1_r;
	logic sup_s2_r;
	logic sup_s3_r;
	logic supply_fault_flag_r;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			sup_s1_r <= 1'b0;
			sup_s2_r <= 1'b0;
			sup_s3_r <= 1'b0;
		end else begin
			sup_s1_r <= SUPPLY_FAULT_IN;
			sup_s2_r <= sup_s1_r;
			sup_s3_r <= sup_s2_r;
		end
	end

	// only an agreed level counts, so a single glitch cannot toggle the flag
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			supply_fault_flag_r <= 1'b0;
		end else if (sup_s2_r == sup_s3_r) begin
			supply_fault_flag_r <= sup_s2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fast and synchronous ready flags; a set beats a clear in the same cycle

	logic fast_cell_data_ready_r;
	logic synchronous_data_ready_r;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			fast_cell_data_ready_r <= 1'b0;
		end else if (evt.fast_done) begin
			fast_cell_data_ready_r <= 1'b1;
		end else if (rd_sync_range || evt.sync_done) begin
			fast_cell_data_ready_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			synchronous_data_ready_r <= 1'b0;
		end else if (evt.sync_done) begin
			synchronous_data_ready_r <= 1'b1;
		end else if (rd_sync_range || evt.fast_done) begin
			synchronous_data_ready_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// periodic control and ready flag

	smsf_pmode_t periodic_update_control_r;
	logic per_request_r;
	logic periodic_result_ready_r;
	logic per_clear;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			periodic_update_control_r <= `SMSF_PMODE_RST;
		end else if (wr_ctrl) begin
			periodic_update_control_r <= bus.wdata[1:0];
		end
	end

	// the engine sees one request pulse per single-request write
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			per_request_r <= 1'b0;
		end else begin
			per_request_r <= wr_once;
		end
	end

	// reads clear only in automatic mode; in single-request mode only the write does
	assign per_clear = (rd_per_range && periodic_update_control_r == `SMSF_PMODE_AUTO)
		|| wr_once;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			periodic_result_ready_r <= 1'b0;
		end else if (evt.per_done) begin
			periodic_result_ready_r <= 1'b1;
		end else if (per_clear) begin
			periodic_result_ready_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per input sample counters and application result registers

	logic [APP_N-1:0] app_ready;
	logic [`SMSF_DW-1:0] app_result_r [APP_N];

	genvar gi;
	generate
		for (gi = 0; gi < APP_N; gi++) begin : g_app
			logic [CW-1:0] cnt_r;
			logic rd_me;

			assign rd_me = bus.rd && bus.addr == `SMSF_OFF_APP_FIRST + 16'(gi);
			assign app_ready[gi] = cnt_r >= SAMPLES_FULL;

			// counter saturates so a long idle period cannot wrap it back below the threshold
			always_ff @(posedge CLK_IN) begin
				if (!RST_N_IN) begin
					cnt_r <= '0;
				end else if (APP_CAPTURE_IN[gi] && app_ready[gi]) begin
					cnt_r <= '0;
				end else if (APP_SAMPLE_IN[gi] && !app_ready[gi]) begin
					cnt_r <= cnt_r + CW'(1);
				end
			end

			// a capture accepted in the read cycle (input ready) wins, so its fresh value is not cleared by the read
			always_ff @(posedge CLK_IN) begin
				if (!RST_N_IN) begin
					app_result_r[gi] <= `SMSF_APP_INVALID;
				end else if (APP_CAPTURE_IN[gi] && app_ready[gi]) begin
					app_result_r[gi] <= APP_VALUE_IN;
				end else if (rd_me) begin
					app_result_r[gi] <= `SMSF_APP_INVALID;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// status word

	logic [`SMSF_DW-1:0] status_word;

	always_comb begin
		status_word = '0;
		status_word[`SMSF_BIT_SUPPLY] = supply_fault_flag_r;
		status_word[`SMSF_BIT_FAST] = fast_cell_data_ready_r;
		status_word[`SMSF_BIT_SYNC] = synchronous_data_ready_r;
		status_word[`SMSF_BIT_PER] = periodic_result_ready_r;
		status_word[`SMSF_BIT_APP_HI:`SMSF_BIT_APP_LO] = app_ready[3:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, write-one clear, enable

	logic [`SMSF_IRQ_W-1:0] irq_set;
	logic [`SMSF_IRQ_W-1:0] irq_stat_r;
	logic [`SMSF_IRQ_W-1:0] irq_en_r;
	logic irq_r;
	logic sup_prev_r;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			sup_prev_r <= 1'b0;
		end else begin
			sup_prev_r <= supply_fault_flag_r;
		end
	end

	always_comb begin
		irq_set = '0;
		irq_set[`SMSF_IRQ_FAST] = evt.fast_done;
		irq_set[`SMSF_IRQ_SYNC] = evt.sync_done;
		irq_set[`SMSF_IRQ_PER] = evt.per_done;
		irq_set[`SMSF_IRQ_SUPPLY] = supply_fault_flag_r && !sup_prev_r;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			irq_stat_r <= '0;
		end else if (wr_irq_clr) begin
			irq_stat_r <= (irq_stat_r & ~bus.wdata[`SMSF_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			irq_en_r <= '0;
		end else if (wr_irq_en) begin
			irq_en_r <= bus.wdata[`SMSF_IRQ_W-1:0];
		end
	end

	// one cycle behind the status so the pin comes straight from a flop
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_en_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port; status reads have no side effects and status writes decode nowhere

	logic [`SMSF_DW-1:0] rdata_nxt;
	logic [`SMSF_DW-1:0] rdata_r;
	logic [1:0] app_idx;

	assign app_idx = 2'(bus.addr - `SMSF_OFF_APP_FIRST);

	always_comb begin
		rdata_nxt = '0;
		if (bus.rd) begin
			if (bus.addr == `SMSF_OFF_STATUS) begin
				rdata_nxt = status_word;
			end else if (bus.addr >= `SMSF_OFF_APP_FIRST && bus.addr <= `SMSF_OFF_APP_LAST) begin
				rdata_nxt = app_result_r[app_idx];
			end else if (bus.addr == `SMSF_OFF_PER_CTRL) begin
				rdata_nxt = {14'h0000, periodic_update_control_r};
			end else if (bus.addr == `SMSF_OFF_IRQ_STAT) begin
				rdata_nxt = {12'h000, irq_stat_r};
			end else if (bus.addr == `SMSF_OFF_IRQ_EN) begin
				rdata_nxt = {12'h000, irq_en_r};
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign RDATA_OUT = rdata_r;
	assign PER_MODE_OUT = periodic_update_control_r;
	assign PER_REQUEST_OUT = per_request_r;
	assign IRQ_OUT = irq_r;

endmodule // smsf_status
`default_nettype wire

// ===== verif/smsf_status_chk.sv
// concurrent checks on the ports of the status flag block
`timescale 1ns/100ps
`default_nettype none
`include "smsf_cfg.svh"
module smsf_status_chk #(
	parameter int APP_N = `SMSF_APP_N
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [`SMSF_AW-1:0] ADDR_IN,
	input wire logic [`SMSF_DW-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [`SMSF_DW-1:0] RDATA_OUT,
	input wire logic SUPPLY_FAULT_IN,
	input wire logic FAST_DONE_IN,
	input wire logic SYNC_DONE_IN,
	input wire logic PER_DONE_IN,
	input wire logic [APP_N-1:0] APP_CAPTURE_IN,
	input wire logic [1:0] PER_MODE_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// no event and no bus access, so none of status bits 10:8 can move in that cycle
	logic quiet;
	logic calm;
	assign quiet = !FAST_DONE_IN && !SYNC_DONE_IN && !PER_DONE_IN;
	assign calm = quiet && !RD_IN && !WR_IN;
	sequence st_rd; RD_IN && ADDR_IN == `SMSF_OFF_STATUS && quiet; endsequence
	sequence app_rd; RD_IN && ADDR_IN == `SMSF_OFF_APP_FIRST && !APP_CAPTURE_IN[0]; endsequence
	// a quiet cycle and then a status read, so the flag state seen is the one the event left
	sequence later_rd; calm ##1 st_rd; endsequence
	////////////////////////////////////////////////////////////////
	reserved_zero_a: assert property (RD_IN && ADDR_IN == `SMSF_OFF_STATUS |=> RDATA_OUT[11] == 1'b0
		&& RDATA_OUT[7:4] == 4'h0) else $error("reserved status bits not zero");
	fast_set_a: assert property (FAST_DONE_IN ##1 later_rd |=> RDATA_OUT[10])
		else $error("fast data flag not set");
	sync_set_a: assert property (SYNC_DONE_IN ##1 later_rd |=> RDATA_OUT[9])
		else $error("sync data flag not set");
	per_set_a: assert property (PER_DONE_IN ##1 later_rd |=> RDATA_OUT[8])
		else $error("periodic flag not set");
	sync_clear_a: assert property (RD_IN && quiet && ADDR_IN inside {[`SMSF_OFF_SYNC_FIRST:`SMSF_OFF_SYNC_LAST]}
		##1 later_rd |=> RDATA_OUT[10:9] == 2'h0) else $error("sync range read left a flag set");
	auto_clear_a: assert property (PER_MODE_OUT == `SMSF_PMODE_AUTO && RD_IN && quiet
		&& ADDR_IN inside {[`SMSF_OFF_PER_FIRST:`SMSF_OFF_PER_LAST]} ##1 later_rd |=> !RDATA_OUT[8])
		else $error("periodic read did not clear flag");
	once_clear_a: assert property (WR_IN && quiet && ADDR_IN == `SMSF_OFF_PER_CTRL
		&& WDATA_IN[1:0] == `SMSF_PMODE_ONCE ##1 later_rd |=> !RDATA_OUT[8]) else $error("single request kept flag");
	supply_seen_a: assert property (SUPPLY_FAULT_IN [*6] ##0 st_rd |=> RDATA_OUT[12])
		else $error("supply fault not reported");
	app_invalid_a: assert property (app_rd ##1 !APP_CAPTURE_IN[0] ##1 app_rd |=> RDATA_OUT == `SMSF_APP_INVALID)
		else $error("application result not invalid after read");
endmodule // smsf_status_chk
bind smsf_status smsf_status_chk #(.APP_N(APP_N)) chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
	.WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .SUPPLY_FAULT_IN(SUPPLY_FAULT_IN),
	.FAST_DONE_IN(FAST_DONE_IN), .SYNC_DONE_IN(SYNC_DONE_IN), .PER_DONE_IN(PER_DONE_IN),
	.APP_CAPTURE_IN(APP_CAPTURE_IN), .PER_MODE_OUT(PER_MODE_OUT));
`default_nettype wire

// ===== verif/smsf_status_tb.sv
// self-checking bench for the status flag block
`timescale 1ns/100ps
`default_nettype none
`include "smsf_cfg.svh"
module smsf_status_tb;
	import smsf_pkg::*;
	localparam logic [15:0] st = `SMSF_OFF_STATUS;
	localparam logic [15:0] ap = `SMSF_OFF_APP_FIRST;
	localparam logic [15:0] pc = `SMSF_OFF_PER_CTRL;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sup = 1'b0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, val = 16'h1234, rdata;
	logic [2:0] evt = 3'h0;
	logic [3:0] smp = 4'h0, cap = 4'h0;
	logic req, irq;
	logic [1:0] mode;
	int miscompares = 0, n_checks = 0;
	always #25 clk = ~clk;
	smsf_status dut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
		.RDATA_OUT(rdata), .SUPPLY_FAULT_IN(sup), .FAST_DONE_IN(evt[2]), .SYNC_DONE_IN(evt[1]),
		.PER_DONE_IN(evt[0]), .APP_SAMPLE_IN(smp), .APP_CAPTURE_IN(cap), .APP_VALUE_IN(val),
		.PER_MODE_OUT(mode), .PER_REQUEST_OUT(req), .IRQ_OUT(irq));
	////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic put(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic get(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp("rdata", e, rdata);
	endtask
	task automatic pulse(input logic [2:0] e, input logic [3:0] s, input logic [3:0] c);
		@(posedge clk);
		evt <= e;
		smp <= s;
		cap <= c;
		@(posedge clk);
		evt <= 3'h0;
		smp <= 4'h0;
		cap <= 4'h0;
	endtask
	task automatic irq_chk(input logic e);
		repeat (2) @(posedge clk);
		#1 cmp("irq", {15'h0000, e}, {15'h0000, irq});
	endtask
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		get(st, 16'h0000);
		get(ap, 16'h8000);
		pulse(3'h4, 4'h0, 4'h0);
		put(st, 16'hFFFF);
		get(st, 16'h0400);
		get(st, 16'h0400);
		pulse(3'h2, 4'h0, 4'h0);
		get(st, 16'h0200);
		pulse(3'h4, 4'h0, 4'h0);
		get(st, 16'h0400);
		get(`SMSF_OFF_SYNC_LAST, 16'h0000);
		get(st, 16'h0000);
		pulse(3'h2, 4'h0, 4'h0);
		get(`SMSF_OFF_SYNC_FIRST, 16'h0000);
		get(st, 16'h0000);
		put(pc, 16'h0001);
		get(pc, 16'h0001);
		cmp("mode", 16'h0001, {14'h0000, mode});
		pulse(3'h1, 4'h0, 4'h0);
		get(st, 16'h0100);
		get(`SMSF_OFF_PER_LAST, 16'h0000);
		get(st, 16'h0000);
		put(pc, 16'h0002);
		#1 cmp("req", 16'h0001, {15'h0000, req});
		cmp("mode", 16'h0002, {14'h0000, mode});
		pulse(3'h1, 4'h0, 4'h0);
		get(`SMSF_OFF_PER_FIRST, 16'h0000);
		cmp("req", 16'h0000, {15'h0000, req});
		get(st, 16'h0100);
		put(pc, 16'h0002);
		get(st, 16'h0000);
		@(posedge clk);
		sup <= 1'b1;
		repeat (6) @(posedge clk);
		get(st, 16'h1000);
		@(posedge clk);
		sup <= 1'b0;
		repeat (6) @(posedge clk);
		get(st, 16'h0000);
		// fifteen samples on every input is one short of ready
		repeat (15) pulse(3'h0, 4'hF, 4'h0);
		get(st, 16'h0000);
		pulse(3'h0, 4'hF, 4'h0);
		get(st, 16'h000F);
		pulse(3'h0, 4'h0, 4'h1);
		get(st, 16'h000E);
		get(ap, 16'h1234);
		get(ap, 16'h8000);
		get(16'h0000, 16'h0000);
		put(`SMSF_OFF_IRQ_EN, 16'h0002);
		irq_chk(1'b1);
		get(`SMSF_OFF_IRQ_EN, 16'h0002);
		put(`SMSF_OFF_IRQ_CLR, 16'h000F);
		irq_chk(1'b0);
		get(`SMSF_OFF_IRQ_STAT, 16'h0000);
		pulse(3'h2, 4'h0, 4'h0);
		irq_chk(1'b1);
		get(`SMSF_OFF_IRQ_STAT, 16'h0002);
		put(`SMSF_OFF_IRQ_EN, 16'h0000);
		irq_chk(1'b0);
		end_of_test();
	end
endmodule // smsf_status_tb
`default_nettype wire
